/* common/famr_consts.vh */
// Purpose: Shared constants of the flash address-mode, reset and read command block.
// Assumes: A core clock of 20 MHz; opcodes are eight bits wide.
// Notes: Included by its bare name from every design file that needs it.
`ifndef FAMR_CONSTS_VH
`define FAMR_CONSTS_VH

// ******************************************
// Opcodes
// ******************************************
`define FAMR_OP_WREN 8'h06
`define FAMR_OP_WRDI 8'h04
`define FAMR_OP_RD_EXT 8'hC8
`define FAMR_OP_WR_EXT 8'hC5
`define FAMR_OP_EN4B 8'hB7
`define FAMR_OP_EX4B 8'hE9
`define FAMR_OP_ENQ 8'h38
`define FAMR_OP_EXQ 8'hFF
`define FAMR_OP_RSTEN 8'h66
`define FAMR_OP_RST 8'h99
`define FAMR_OP_READ 8'h03
`define FAMR_OP_READ4 8'h13
`define FAMR_OP_FAST 8'h0B

// ******************************************
// Reset values, field sizes and timing
// ******************************************
`define FAMR_EXT_RST 8'h00
`define FAMR_QPI_DUMMY_RST 4'h4
`define FAMR_SPI_DUMMY 4'h8
`define FAMR_ABITS_3B 6'h18
`define FAMR_ABITS_4B 6'h20
`define FAMR_BYTE_BITS 6'h08
`define FAMR_CLK_MHZ 20
`define FAMR_RST_WAIT_US 300
`define FAMR_RST_CNT_W 13

`endif

/* hw/famr_buf.v */
// Purpose: Two-entry buffer between the array read port and the output shifter.
// Assumes: Push and pop come from the same clock domain.
// Notes: Ready on the filling side is a flop; flush wins over a push.
`timescale 1ns/1ps
module famr_buf #(
   parameter W = 8
) (
   input wire core_clk,
   input wire rst_n,
   input wire flush,
   input wire in_valid,
   output reg in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:1];
   reg [1:0] cnt;
   reg wp;
   reg rp;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   reg [1:0] next_cnt;

   assign out_valid = (cnt != 2'h0);
   assign out_data = mem[rp];

   // Entry count after this cycle's push and pop.
   always @* begin
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
      if (flush) begin
         next_cnt = 2'h0;
      end
   end

   // Pointers, storage and the registered ready.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         cnt <= 2'h0;
         wp <= 1'b0;
         rp <= 1'b0;
         in_ready <= 1'b1;
      end else begin
         cnt <= next_cnt;
         in_ready <= (next_cnt != 2'h2);
         if (flush) begin
            wp <= 1'b0;
            rp <= 1'b0;
         end else begin
            if (push) begin
               mem[wp] <= in_data;
               wp <= ~wp;
            end
            if (pop) begin
               rp <= ~rp;
            end
         end
      end
   end
endmodule

/* hw/famr_sync.v */
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level from outside the core clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module famr_sync #(
   parameter W = 6,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire core_clk,
   input wire rst_n,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta;

   // Two flip-flops in series, cleared to the idle pin levels.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         meta <= RST;
         dout <= RST;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

/* hw/famr_top.v */
// Purpose: Command decoder for address mode, interface mode, soft reset and reads.
// Assumes: Pins arrive unsynchronised; serial clock is far slower than core_clk.
// Notes: Frame state commits when chip select rises, ext_addr also on an address taken in 4-byte mode; reads stream from a byte array.
//
// What the document asks of this block and its host
// RULE_01: In 3-byte mode address bits 31..24 come from the upper-address register.
// RULE_02: Opcode C8h shifts the upper-address register out, MSB first, on falling edges.
// RULE_03: In 4-byte mode the upper-address register is not used for addressing.
// RULE_04: C5h plus one byte loads the register only when write latch is set.
// RULE_05: Power-up and soft reset clear the upper-address register.
// RULE_06: With 4-byte mode on, a full address overwrites the upper-address register.
// RULE_07: Host should recheck the upper-address register after leaving 4-byte mode.
// RULE_08: B7h ending with select high selects 32-bit addresses.
// RULE_09: E9h selects 24-bit addresses with the register as top byte.
// RULE_10: 38h enters quad command mode only when quad enable is set.
// RULE_11: Power-up starts in single-line mode; the two modes never coexist.
// RULE_12: FFh in quad command mode returns to single-line mode.
// RULE_13: Mode switches keep write latch, suspend and wrap settings.
// RULE_14: Soft reset restores power-on state and clears volatile flags.
// RULE_15: Reset needs 66h then 99h; anything else disarms it.
// RULE_16: For about 300us after reset every instruction is refused.
// RULE_17: Host should check busy and suspend flags before resetting.
// RULE_18: 03h takes an address, then streams bytes on falling edges, incrementing.
// RULE_19: Reads during a write cycle are rejected without effect.
// RULE_20: 13h always takes a 32-bit address.
// RULE_21: 13h is accepted only in single-line mode.
// RULE_22: 0Bh takes address plus dummy, then streams incrementing bytes.
// RULE_23: Quad command mode fast-read dummy count is 4 after reset.
// RULE_24: In quad command mode opcodes arrive on four lines in two clocks.
// RULE_25: A frame cut short changes no state.
`timescale 1ns/1ps
`include "famr_consts.vh"
module famr_top #(
   parameter RST_WAIT_CYC = `FAMR_RST_WAIT_US * `FAMR_CLK_MHZ
) (
   input wire core_clk,
   input wire rst_n,
   input wire cs_n,
   input wire sclk,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe,
   input wire quad_enable_bit,
   input wire write_cycle_flag,
   input wire addr_mode_default,
   input wire dummy_set,
   input wire [3:0] dummy_val,
   output reg arr_req,
   output reg [31:0] arr_addr,
   input wire arr_rvalid,
   output wire arr_rready,
   input wire [7:0] arr_rdata,
   output reg [7:0] ext_addr,
   output reg address_size_flag,
   output reg quad_command_mode,
   output reg write_latch_flag,
   output reg soft_reset,
   output reg reset_busy
);
   // ******************************************
   // Frame states
   // ******************************************
   localparam [2:0] ST_REF = 3'h0, ST_OP = 3'h1, ST_ADDR = 3'h2, ST_DUMMY = 3'h3;
   localparam [2:0] ST_DIN = 3'h4, ST_OUT = 3'h5, ST_IGN = 3'h6;

   wire [5:0] pin_s;
   reg sclk_d, cs_d, op_done, extra, din_ok, armed, rd_go, rd_act, pend, drop;
   reg [2:0] st, ocnt;
   reg [31:0] sh, start_addr, fa;
   reg [5:0] pcnt, nab;
   reg [3:0] dcnt, qpi_dummy;
   reg [7:0] op, din, obyte;
   reg [`FAMR_RST_CNT_W-1:0] rst_cnt;
   wire buf_vld;
   wire [7:0] buf_data;

   // ******************************************
   // Pin sampling and edge detection
   // ******************************************
   famr_sync #(.W(6), .RST(6'h20)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .din({cs_n, sclk, io_in}),
      .dout(pin_s)
   );

   wire cs_hi = pin_s[5];
   wire sc = pin_s[4];
   wire rise = sc & ~sclk_d & ~cs_hi;
   wire fall = ~sc & sclk_d & ~cs_hi;
   wire cs_fall = ~cs_hi & cs_d;
   wire cs_rise = cs_hi & ~cs_d;
   wire [5:0] w = quad_command_mode ? 6'h04 : 6'h01;   // Bits per clock. [RULE_24]
   wire [5:0] next_pcnt = pcnt + w;
   wire [31:0] next_sh = quad_command_mode ? {sh[27:0], pin_s[3:0]} : {sh[30:0], pin_s[0]};
   wire [3:0] dneed = quad_command_mode ? qpi_dummy : `FAMR_SPI_DUMMY;

   // Previous sampled levels of clock and select.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= sc;
         cs_d <= cs_hi;
      end
   end

   // ******************************************
   // Frame decoder and committed state
   // ******************************************
   // Bits are taken on rising edges; state changes at the end of a whole frame, and ext_addr also on the last bit of an address taken in 4-byte mode.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         st <= ST_REF;
         sh <= 32'h00000000;
         pcnt <= 6'h00;
         nab <= `FAMR_ABITS_3B;
         dcnt <= 4'h0;
         op <= 8'h00;
         din <= 8'h00;
         op_done <= 1'b0;
         extra <= 1'b0;
         din_ok <= 1'b0;
         armed <= 1'b0;
         rd_go <= 1'b0;
         start_addr <= 32'h00000000;
         ext_addr <= `FAMR_EXT_RST;                       // [RULE_05]
         address_size_flag <= addr_mode_default;
         quad_command_mode <= 1'b0;                       // [RULE_11]
         write_latch_flag <= 1'b0;
         qpi_dummy <= `FAMR_QPI_DUMMY_RST;                // [RULE_23]
         soft_reset <= 1'b0;
         reset_busy <= 1'b0;
         rst_cnt <= {`FAMR_RST_CNT_W{1'b0}};
      end else begin
         soft_reset <= 1'b0;
         rd_go <= 1'b0;
         if (rst_cnt != {`FAMR_RST_CNT_W{1'b0}}) rst_cnt <= rst_cnt - 1'b1;
         reset_busy <= (rst_cnt > {{(`FAMR_RST_CNT_W-1){1'b0}}, 1'b1});
         if (dummy_set) qpi_dummy <= dummy_val;
         if (cs_fall) begin
            st <= reset_busy ? ST_REF : ST_OP;            // [RULE_16]
            pcnt <= 6'h00;
            dcnt <= 4'h0;
            op_done <= 1'b0;
            extra <= 1'b0;
            din_ok <= 1'b0;
         end else if (rise) begin
            case (st)
               ST_OP: begin
                  sh <= next_sh;
                  pcnt <= next_pcnt;
                  if (next_pcnt == `FAMR_BYTE_BITS) begin
                     op <= next_sh[7:0];
                     op_done <= 1'b1;
                     pcnt <= 6'h00;
                     st <= ST_IGN;
                     nab <= address_size_flag ? `FAMR_ABITS_4B : `FAMR_ABITS_3B;
                     case (next_sh[7:0])
                        `FAMR_OP_READ, `FAMR_OP_FAST: begin
                           st <= write_cycle_flag ? ST_IGN : ST_ADDR;       // [RULE_19]
                        end
                        `FAMR_OP_READ4: begin
                           nab <= `FAMR_ABITS_4B;                            // [RULE_20]
                           if (!write_cycle_flag && !quad_command_mode) begin
                              st <= ST_ADDR;                                 // [RULE_21]
                           end
                        end
                        `FAMR_OP_WR_EXT: st <= ST_DIN;
                        `FAMR_OP_RD_EXT: st <= ST_OUT;
                        default: st <= ST_IGN;
                     endcase
                  end
               end
               ST_ADDR: begin
                  sh <= next_sh;
                  pcnt <= next_pcnt;
                  if (next_pcnt == nab) begin
                     rd_go <= 1'b1;
                     st <= (op == `FAMR_OP_FAST) ? ST_DUMMY : ST_OUT;     // [RULE_18]
                     if (nab == `FAMR_ABITS_4B) begin
                        start_addr <= next_sh;                               // [RULE_03]
                        if (address_size_flag) begin
                           ext_addr <= next_sh[31:24];                      // [RULE_06]
                        end
                     end else begin
                        start_addr <= {ext_addr, next_sh[23:0]};            // [RULE_01]
                     end
                  end
               end
               ST_DUMMY: begin
                  dcnt <= dcnt + 1'b1;
                  if (dcnt + 1'b1 == dneed) begin
                     st <= ST_OUT;                                           // [RULE_22]
                  end
               end
               ST_DIN: begin
                  sh <= next_sh;
                  pcnt <= next_pcnt;
                  if (next_pcnt == `FAMR_BYTE_BITS) begin
                     din <= next_sh[7:0];
                     din_ok <= 1'b1;
                     st <= ST_IGN;
                     extra <= 1'b0;
                  end
               end
               ST_IGN: extra <= 1'b1;
               default: st <= st;
            endcase
         end else if (cs_rise) begin
            st <= ST_REF;
            if (op_done) begin
               armed <= (op == `FAMR_OP_RSTEN) && !extra;                   // [RULE_15]
            end
            if (op_done && !extra && st == ST_IGN) begin
               // Frames ending on a whole opcode, or on C5h plus its byte, act here; short or overlong frames never reach it. [RULE_25]
               case (op)
                  `FAMR_OP_WREN: write_latch_flag <= 1'b1;
                  `FAMR_OP_WRDI: write_latch_flag <= 1'b0;
                  `FAMR_OP_WR_EXT: begin
                     if (din_ok && write_latch_flag) begin
                        ext_addr <= din;                                     // [RULE_04]
                     end
                  end
                  `FAMR_OP_EN4B: address_size_flag <= 1'b1;                 // [RULE_08]
                  `FAMR_OP_EX4B: address_size_flag <= 1'b0;                 // [RULE_09]
                  `FAMR_OP_ENQ: begin
                     if (quad_enable_bit) begin
                        quad_command_mode <= 1'b1;                  // [RULE_10] [RULE_13]
                     end
                  end
                  `FAMR_OP_EXQ: quad_command_mode <= 1'b0;          // [RULE_12] [RULE_13]
                  `FAMR_OP_RST: begin
                     if (armed) begin
                        // Power-on state returns; the pulse clears outside flags. [RULE_14]
                        ext_addr <= `FAMR_EXT_RST;                           // [RULE_05]
                        address_size_flag <= addr_mode_default;
                        quad_command_mode <= 1'b0;
                        write_latch_flag <= 1'b0;
                        qpi_dummy <= `FAMR_QPI_DUMMY_RST;                    // [RULE_23]
                        soft_reset <= 1'b1;
                        reset_busy <= 1'b1;                                  // [RULE_16]
                        rst_cnt <= RST_WAIT_CYC[`FAMR_RST_CNT_W-1:0];
                     end
                  end
                  default: armed <= (op == `FAMR_OP_RSTEN);         // Only 66h arms. [RULE_15]
               endcase
            end
         end
      end
   end

   // ******************************************
   // Array fetch and read buffer
   // ******************************************
   wire issue = rd_act & ~pend & ~arr_req & arr_rready & ~cs_rise;
   wire accept = arr_rvalid & arr_rready;
   wire pop = fall & (st == ST_OUT) & (ocnt == 3'h0) & (op != `FAMR_OP_RD_EXT) & buf_vld;

   // One byte in flight; the address steps after each request. [RULE_18] [RULE_22]
   always @(posedge core_clk) begin
      if (!rst_n) begin
         rd_act <= 1'b0;
         pend <= 1'b0;
         drop <= 1'b0;
         fa <= 32'h00000000;
         arr_req <= 1'b0;
         arr_addr <= 32'h00000000;
      end else begin
         arr_req <= issue;
         if (issue) begin
            arr_addr <= fa;
            fa <= fa + 32'h00000001;
            pend <= 1'b1;
         end else if (accept) begin
            pend <= 1'b0;
         end
         if (rd_go) begin
            rd_act <= 1'b1;
            fa <= start_addr;
         end else if (cs_rise) begin
            rd_act <= 1'b0;
         end
         if (cs_rise && (pend || arr_req)) begin
            drop <= 1'b1;
         end else if (accept) begin
            drop <= 1'b0;
         end
      end
   end

   famr_buf #(.W(8)) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flush(cs_rise | drop),
      .in_valid(arr_rvalid),
      .in_ready(arr_rready),
      .in_data(arr_rdata),
      .out_valid(buf_vld),
      .out_ready(pop),
      .out_data(buf_data)
   );

   // ******************************************
   // Output shifter
   // ******************************************
   wire [7:0] src = (op == `FAMR_OP_RD_EXT) ? ext_addr : (buf_vld ? buf_data : 8'hFF);

   // Data leaves on falling edges, high bits first; select high releases the lines.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
         ocnt <= 3'h0;
         obyte <= 8'h00;
      end else if (cs_hi) begin
         io_oe <= 4'h0;
         ocnt <= 3'h0;
      end else if (fall && st == ST_OUT) begin
         ocnt <= ocnt + w[2:0];
         if (ocnt == 3'h0) begin
            io_out <= quad_command_mode ? src[7:4] : {2'h0, src[7], 1'b0};   // [RULE_02]
            obyte <= quad_command_mode ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
         end else begin
            io_out <= quad_command_mode ? obyte[7:4] : {2'h0, obyte[7], 1'b0};
            obyte <= quad_command_mode ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
         end
         io_oe <= quad_command_mode ? 4'hF : 4'h2;
      end
   end
endmodule

/* verif/famr_host.sv */
// Purpose: Host controller model driving select, serial clock and data pins.
// Assumes: Calls start just after a core clock edge.
// Notes: Low 3, high 5 core cycles (400 ns); the long high phase lets the first byte arrive.
`timescale 1ns/1ps
module famr_host (
   input wire core_clk,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] drv,
   input wire [3:0] io_out
);
   // ******************************************
   // Frame tasks
   // ******************************************
   logic quad;
   // Pins idle with select high and the serial clock low.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      drv = 4'h0;
      quad = 1'b0;
   end
   // Opens a frame.
   task automatic open_frame();
      @(posedge core_clk);
      cs_n <= 1'b0;
   endtask
   // Ends a frame, then parks the clock and lets the synchroniser see select high.
   task automatic close_frame();
      repeat (2) @(posedge core_clk);
      cs_n <= 1'b1;
      @(posedge core_clk);
      sclk <= 1'b0;
      drv <= ~drv;
      repeat (8) @(posedge core_clk);
   endtask
   // Gives n serial clocks of b, MSB first, and collects what the device drives.
   task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
      logic [7:0] sh;
      sh = b;
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         sclk <= 1'b0;
         drv <= quad ? sh[7:4] : {3'b000, sh[7]};
         repeat (3) @(posedge core_clk);
         sclk <= 1'b1;
         @(posedge core_clk);
         #1;
         r = quad ? {r[3:0], io_out} : {r[6:0], io_out[1]};
         sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
         repeat (3) @(posedge core_clk);
      end
   endtask
endmodule

/* verif/famr_monitor.sv */
// Purpose: Concurrent checks on the ports of the command decoder.
// Assumes: One core clock domain with a synchronous active-low reset.
// Notes: Attached to the decoder by a bind in the bench top file.
`timescale 1ns/1ps
module famr_monitor #(
   parameter RST_WAIT_CYC = 6000
) (
   input wire core_clk,
   input wire rst_n,
   input wire cs_n,
   input wire quad_enable_bit,
   input wire write_cycle_flag,
   input wire arr_req,
   input wire [3:0] io_oe,
   input wire [7:0] ext_addr,
   input wire address_size_flag,
   input wire quad_command_mode,
   input wire write_latch_flag,
   input wire soft_reset,
   input wire reset_busy
);
   // ******************************************
   // Recovery length counter and properties
   // ******************************************
   int unsigned busy_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Counts the cycles for which recovery has been reported.
   always @(posedge core_clk) begin
      if (!rst_n || !reset_busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   a_ext_cleared: assert property (soft_reset |-> ##[0:2] (ext_addr == 8'h00))
      else $error("upper address not cleared by soft reset");
   a_state_cleared: assert property (soft_reset |-> ##[0:2] (!write_latch_flag &&
      !quad_command_mode)) else $error("volatile state kept over soft reset");
   a_busy_follows: assert property (soft_reset |-> ##[0:2] reset_busy)
      else $error("recovery not reported after soft reset");
   a_busy_length: assert property ($fell(reset_busy) |-> (busy_cnt + 2 >= RST_WAIT_CYC &&
      busy_cnt <= RST_WAIT_CYC + 2)) else $error("recovery length wrong");
   a_srst_pulse: assert property (soft_reset |=> !soft_reset)
      else $error("soft reset longer than one cycle");
   a_qpi_needs_qe: assert property ($rose(quad_command_mode) |-> quad_enable_bit)
      else $error("quad mode entered without quad enable");
   a_mode_at_cs: assert property ((!$stable(quad_command_mode) ||
      !$stable(address_size_flag)) |-> cs_n) else $error("mode changed inside a frame");
   a_oe_idle: assert property (cs_n [*6] |-> (io_oe == 4'h0))
      else $error("pins driven while deselected");
   a_oe_mode: assert property ((io_oe != 4'h0) |->
      (io_oe == (quad_command_mode ? 4'hF : 4'h2))) else $error("output lanes wrong for mode");
   a_no_req_busy: assert property (arr_req |-> (!reset_busy && !write_cycle_flag))
      else $error("array read while busy");
   a_ext_guard: assert property (!$stable(ext_addr) |-> (write_latch_flag ||
      address_size_flag || reset_busy || soft_reset)) else $error("upper address changed unguarded");
   c_soft_reset: cover property (soft_reset);
   c_quad_on: cover property ($rose(quad_command_mode));
   c_req_4byte: cover property (arr_req && address_size_flag);
endmodule

/* verif/flash_addr_mode_reset_read_cmds_tb.sv */
// Purpose: Self-checking bench for the command decoder.
// Assumes: Array answers one cycle after each request.
// Notes: Recovery is shortened to 200 cycles.
`timescale 1ns/1ps
module flash_addr_mode_reset_read_cmds_tb;
   // ******************************************
   // Harness, array model and shared tasks
   // ******************************************
   localparam int WAIT_CYC = 200;
   logic core_clk, rst_n, qe, wcf, amd, dummy_set, arr_rvalid;
   logic [3:0] dummy_val;
   logic [7:0] arr_rdata, r, b0, b1;
   logic [31:0] first_addr;
   wire cs_n, sclk, arr_req, arr_rready, soft_reset, reset_busy;
   wire address_size_flag, quad_command_mode, write_latch_flag;
   wire [3:0] io_out, io_oe, io_in, drv;
   wire [31:0] arr_addr;
   wire [7:0] ext_addr;
   int n_mismatch, checks_done, n_req;
   // Device lanes win where enabled, the host elsewhere.
   assign io_in = (io_oe & io_out) | (~io_oe & drv);
   famr_top #(.RST_WAIT_CYC(WAIT_CYC)) u_dut (.core_clk, .rst_n, .cs_n, .sclk, .io_in, .io_out,
      .io_oe, .quad_enable_bit(qe), .write_cycle_flag(wcf), .addr_mode_default(amd), .dummy_set,
      .dummy_val, .arr_req, .arr_addr, .arr_rvalid, .arr_rready, .arr_rdata, .ext_addr,
      .address_size_flag, .quad_command_mode, .write_latch_flag, .soft_reset, .reset_busy);
   famr_host u_host (.core_clk, .cs_n, .sclk, .drv, .io_out);
   // Makes the 50 ns core clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Array byte is its address low byte XOR A5; first request of a frame is kept.
   always @(posedge core_clk) begin
      if (arr_req) begin
         arr_rvalid <= 1'b1;
         arr_rdata <= arr_addr[7:0] ^ 8'hA5;
         if (n_req == 0) first_addr <= arr_addr;
         n_req <= n_req + 1;
      end else if (arr_rvalid && arr_rready) begin
         arr_rvalid <= 1'b0;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] b);
      u_host.xfer(b, u_host.quad ? 2 : 8, r);
   endtask
   task automatic cmd(input logic [7:0] op);
      u_host.open_frame();
      send(op);
      u_host.close_frame();
   endtask
   // Upper-address write with n data clocks; a short count cuts the frame.
   task automatic wr_ext(input logic [7:0] v, input int n);
      u_host.open_frame();
      send(8'hC5);
      u_host.xfer(v, n, r);
      u_host.close_frame();
   endtask
   task automatic rd_ext();
      u_host.open_frame();
      send(8'hC8);
      send(8'h00);
      u_host.close_frame();
   endtask
   // Read with nab address bytes and nd dummy clocks, two data bytes taken.
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input int nab, input int nd);
      n_req = 0;
      u_host.open_frame();
      send(op);
      for (int i = nab - 1; i >= 0; i--) send(a[8*i +: 8]);
      if (nd > 0) u_host.xfer(8'h00, nd, r);
      send(8'hFF);
      b0 = r;
      send(8'hFF);
      b1 = r;
      u_host.close_frame();
   endtask
   // ******************************************
   // Scenarios
   // ******************************************
   task automatic s_ext_reg();
      check(ext_addr, 8'h00);
      check(quad_command_mode, 1'b0);
      wr_ext(8'h5A, 8);
      check(ext_addr, 8'h00);
      cmd(8'h06);
      wr_ext(8'h5A, 8);
      check(ext_addr, 8'h5A);
      wr_ext(8'h33, 4);
      check(ext_addr, 8'h5A);
      rd_ext();
      check(r, 8'h5A);
   endtask
   task automatic s_reads();
      rd(8'h03, 32'h0000_1234, 3, 0);
      check(first_addr, 32'h5A00_1234);
      check({b0, b1}, 16'h9190);
      rd(8'h13, 32'h0300_00FF, 4, 0);
      check(first_addr, 32'h0300_00FF);
      check({b0, b1, ext_addr}, 24'h5AA55A);
      rd(8'h0B, 32'h0000_0010, 3, 8);
      check({b0, b1}, 16'hB5B4);
      wcf <= 1'b1;
      rd(8'h03, 32'h0000_0020, 3, 0);
      check(n_req, 0);
      wcf <= 1'b0;
   endtask
   task automatic s_addr_mode();
      cmd(8'hB7);
      check(address_size_flag, 1'b1);
      rd(8'h03, 32'h7700_0040, 4, 0);
      check(first_addr, 32'h7700_0040);
      check(ext_addr, 8'h77);
      cmd(8'hE9);
      check(address_size_flag, 1'b0);
      rd_ext();
      check(r, 8'h77);
      rd(8'h03, 32'h0000_0008, 3, 0);
      check(first_addr, 32'h7700_0008);
   endtask
   task automatic s_quad();
      cmd(8'h38);
      check(quad_command_mode, 1'b0);
      qe <= 1'b1;
      cmd(8'h38);
      check(quad_command_mode, 1'b1);
      check(write_latch_flag, 1'b1);
      u_host.quad = 1'b1;
      rd_ext();
      check(r, 8'h77);
      rd(8'h13, 32'h0000_0030, 4, 0);
      check(n_req, 0);
      rd(8'h0B, 32'h0000_0050, 3, 4);
      check({b0, b1}, 16'hF5F4);
      cmd(8'hFF);
      u_host.quad = 1'b0;
      check(quad_command_mode, 1'b0);
      check(write_latch_flag, 1'b1);
   endtask
   task automatic s_soft_reset();
      cmd(8'hB7);
      cmd(8'h66); // Busy input is low.
      cmd(8'h06);
      cmd(8'h99);
      check({reset_busy, address_size_flag, ext_addr}, 10'h177);
      cmd(8'h66);
      cmd(8'h99);
      check({reset_busy, write_latch_flag, address_size_flag}, 3'b100);
      check(ext_addr, 8'h00);
      cmd(8'h06);
      check(write_latch_flag, 1'b0);
      for (int i = 0; i < 400 && reset_busy !== 1'b0; i++) @(posedge core_clk);
      check(reset_busy, 1'b0);
      if (reset_busy !== 1'b0) end_of_test();
      cmd(8'h06);
      check(write_latch_flag, 1'b1);
   endtask
   // Resets, then runs every scenario in turn.
   initial begin
      rst_n = 1'b0;
      qe = 1'b0;
      wcf = 1'b0;
      amd = 1'b0;
      dummy_set = 1'b0;
      dummy_val = 4'h4;
      arr_rvalid = 1'b0;
      arr_rdata = 8'h00;
      n_mismatch = 0;
      checks_done = 0;
      n_req = 0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      s_ext_reg();
      s_reads();
      s_addr_mode();
      s_quad();
      s_soft_reset();
      end_of_test();
   end
endmodule
bind famr_top famr_monitor #(.RST_WAIT_CYC(RST_WAIT_CYC)) u_mon (.core_clk, .rst_n, .cs_n,
   .quad_enable_bit, .write_cycle_flag, .arr_req, .io_oe, .ext_addr, .address_size_flag,
   .quad_command_mode, .write_latch_flag, .soft_reset, .reset_busy);
